// [logic/ppu_pin_sync.sv]
// Two-stage synchronisers for the host-driven pins
module ppu_pin_sync (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Raw pins
	input wire logic slave_select,
	input wire logic read_strobe_in,
	input wire logic write_strobe_in,
	input wire logic [1:0] slave_addr_inputs,
	input wire logic [7:0] port_data_in,
	// Synchronised levels
	ppu_sync_if.src sy
);
	logic [ppu_pkg::SYNC_W-1:0] raw;
	logic [ppu_pkg::SYNC_W-1:0] meta;
	logic [ppu_pkg::SYNC_W-1:0] held;

	assign raw = {slave_select, read_strobe_in, write_strobe_in, slave_addr_inputs, port_data_in};

	for (genvar g = 0; g < ppu_pkg::SYNC_W; g++) begin : g_bit
		always_ff @(posedge clk_sys) begin
			if (srst) begin
				meta[g] <= 1'b0;
				held[g] <= 1'b0;
			end else begin
				meta[g] <= raw[g];
				held[g] <= meta[g];
			end
		end
	end

	assign sy.cs = held[12];
	assign sy.rd = held[11];
	assign sy.wr = held[10];
	assign sy.addr = held[9:8];
	assign sy.data = held[7:0];
endmodule

// [logic/ppu_pkg.sv]
// Constants and types shared by the parallel port unit files
package ppu_pkg;
	localparam logic [1:0] MODE_ADDR_SLAVE = 2'h1;
	localparam logic [1:0] MODE_MST_SEP = 2'h2;
	localparam logic [1:0] MODE_MST_COMB = 2'h3;
	localparam logic [1:0] MUX_DEMUX = 2'h0;
	localparam logic [1:0] MUX_PART = 2'h1;
	localparam logic [1:0] MUX_FULL = 2'h2;
	localparam logic [1:0] STEP_INC = 2'h1;
	localparam logic [1:0] STEP_DEC = 2'h2;
	localparam logic [1:0] CSF_ONE = 2'h1;
	localparam logic [1:0] CSF_BOTH = 2'h2;
	localparam int NUM_BYTES = 4;
	localparam int PIN_LATCH_LO = 0;
	localparam int PIN_LATCH_HI = 1;
	localparam int PIN_CS1 = 14;
	localparam int PIN_CS2 = 15;
	localparam int HI_CS1 = 6;
	localparam int HI_CS2 = 7;
	localparam int RD_CYCLES = 5;
	localparam int SYNC_W = 13;
	localparam logic [15:0] MASK_ALL = 16'hffff;
	localparam logic [15:0] MASK_NO_CS2 = 16'h7fff;
	localparam logic [15:0] MASK_NO_CS = 16'h3fff;
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	localparam logic [15:0] ADDR_STEP = 16'h0001;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	typedef enum logic [2:0] {
		M_IDLE,
		M_ADDR_LO,
		M_ADDR_HI,
		M_DATA_LO,
		M_DATA_HI
	} ppu_mst_state_type;
endpackage

// [logic/ppu_port.sv]
// Parallel port unit: addressable slave buffers and bus master
// Overview of operation
// - Slave mode 01 uses two address inputs to pick one of four bytes.
// - Address 00..11 maps to buffer bytes 0..3, in and out alike.
// - Select plus read drives the addressed output byte onto the data bus.
// - Host read sets byte empty flag; all four empty sets aggregate flag.
// - Reading an already empty output byte raises the underflow flag.
// - Select plus write captures the data bus into the addressed input byte.
// - Host write sets byte full flag; all four full sets aggregate flag.
// - Write to a full input byte raises overflow and drops the byte.
// - Master operation needs unit enable and mode 10 or 11.
// - Pin enable bits route functions to pins, else pins stay general I/O.
// - An enabled address pin drives its master address bit.
// - Address pin enables 0 and 1 also gate the latch strobes.
// - Mode 11 drives direction plus enable; mode 10 separate read/write.
// - Each control output has its polarity; shared pins share one bit.
// - Wide words go low byte first, byte strobe during the high byte.
// - Mux 00 keeps address only on the dedicated address pins.
// - Mux 01 adds a cycle with low address on data, latch-low active.
// - Mux 10 adds low then high address cycles with their latch strobes.
// - Chip-select positions read zero in the multiplexed high address byte.
// - Two chip selects share the top address bits, set by a 2-bit field.
// - Address steps up or down once per finished access as busy drops.
// - Chip-select bits hold during stepping; plain address bits count.
// - Encoding 10 is separate strobes; 11 is direction plus enable.
// - Function 10 makes both top bits selects, 01 only the top one.
module ppu_port #(
	parameter int MST_RD_CYCLES = ppu_pkg::RD_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Configuration
	input wire logic port_unit_enable,
	input wire logic [1:0] port_mode,
	input wire logic wide_data_select,
	input wire logic [1:0] addr_mux_select,
	input wire logic [1:0] addr_step_mode,
	input wire logic [1:0] cs_func,
	input wire logic byte_en_pin_enable,
	input wire logic write_pin_enable,
	input wire logic read_pin_enable,
	input wire logic [15:0] addr_pin_enables,
	// Polarity, 1 means active high
	input wire logic pol_read,
	input wire logic pol_write,
	input wire logic pol_be,
	input wire logic pol_latch,
	input wire logic pol_cs1,
	input wire logic pol_cs2,
	// Software buffer access and status
	input wire logic sw_out_wr,
	input wire logic sw_in_rd,
	input wire logic [1:0] sw_index,
	input wire logic [7:0] sw_wdata,
	output logic [7:0] sw_rdata,
	output logic [3:0] out_byte_empty_flag,
	output logic out_all_empty_flag,
	output logic [3:0] in_byte_full_flag,
	output logic in_all_full_flag,
	output logic out_underflow_flag,
	output logic in_overflow_flag,
	input wire logic clr_underflow,
	input wire logic clr_overflow,
	// Master requests
	input wire logic addr_load,
	input wire logic [15:0] addr_load_value,
	input wire logic mst_start,
	input wire logic mst_write,
	input wire logic [15:0] mst_wdata,
	output logic [15:0] mst_rdata,
	output logic [15:0] master_address_reg,
	output logic busy,
	// Slave inputs
	input wire logic slave_select,
	input wire logic [1:0] slave_addr_inputs,
	// Read and write pins
	input wire logic read_strobe_in,
	output logic read_strobe_out,
	output logic read_strobe_oe_n,
	input wire logic write_strobe_in,
	output logic write_strobe_out,
	output logic write_strobe_oe_n,
	// Data bus
	input wire logic [7:0] port_data_in,
	output logic [7:0] port_data_out,
	output logic port_data_oe_n,
	// Byte strobe and address pins
	output logic high_byte_strobe,
	output logic high_byte_oe_n,
	output logic [15:0] addr_pin_out,
	output logic [15:0] addr_pin_oe_n
);
	if (MST_RD_CYCLES < 3 || MST_RD_CYCLES > 8) begin : g_bad_rd
		$error("MST_RD_CYCLES must lie in 3..8");
	end

	function automatic logic act(input logic pol, input logic on);
		return pol ? on : !on;
	endfunction

	ppu_sync_if sy();

	ppu_pin_sync u_sync (
		.clk_sys(clk_sys),
		.srst(srst),
		.slave_select(slave_select),
		.read_strobe_in(read_strobe_in),
		.write_strobe_in(write_strobe_in),
		.slave_addr_inputs(slave_addr_inputs),
		.port_data_in(port_data_in),
		.sy(sy)
	);

	logic master_on;
	logic slave_on;
	assign master_on = port_unit_enable && port_mode[1];
	assign slave_on = port_unit_enable && port_mode == ppu_pkg::MODE_ADDR_SLAVE;

	// Slave strobe edges
	logic rd_act;
	logic wr_act;
	logic rd_q;
	logic wr_q;
	logic rd_ev;
	logic wr_ev;
	logic [1:0] wr_sel;
	logic [7:0] wr_data;
	assign rd_act = sy.cs && sy.rd;
	assign wr_act = sy.cs && sy.wr;
	assign rd_ev = slave_on && rd_act && !rd_q;
	assign wr_ev = slave_on && !wr_act && wr_q;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rd_q <= 1'b0;
			wr_q <= 1'b0;
		end else begin
			rd_q <= rd_act;
			wr_q <= wr_act;
		end
	end

	// Data is taken at the strobe's end from the last sample inside it
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wr_sel <= 2'h0;
			wr_data <= ppu_pkg::BYTE_RESET;
		end else if (wr_act) begin
			wr_sel <= sy.addr;
			wr_data <= sy.data;
		end
	end

	// Buffers and per-byte flags
	logic [7:0] out_buf [ppu_pkg::NUM_BYTES];
	logic [7:0] in_buf [ppu_pkg::NUM_BYTES];

	for (genvar i = 0; i < ppu_pkg::NUM_BYTES; i++) begin : g_byte
		logic rd_hit;
		logic wr_hit;
		logic sw_hit;
		assign rd_hit = rd_ev && sy.addr == 2'(i);
		assign wr_hit = wr_ev && wr_sel == 2'(i);
		assign sw_hit = sw_index == 2'(i);

		always_ff @(posedge clk_sys) begin
			if (srst) begin
				out_buf[i] <= ppu_pkg::BYTE_RESET;
			end else if (sw_out_wr && sw_hit) begin
				out_buf[i] <= sw_wdata;
			end
		end

		// Host read wins over a software refill in the same cycle
		always_ff @(posedge clk_sys) begin
			if (srst) begin
				out_byte_empty_flag[i] <= 1'b1;
			end else if (rd_hit) begin
				out_byte_empty_flag[i] <= 1'b1;
			end else if (sw_out_wr && sw_hit) begin
				out_byte_empty_flag[i] <= 1'b0;
			end
		end

		always_ff @(posedge clk_sys) begin
			if (srst) begin
				in_byte_full_flag[i] <= 1'b0;
				in_buf[i] <= ppu_pkg::BYTE_RESET;
			end else if (wr_hit && !in_byte_full_flag[i]) begin
				in_byte_full_flag[i] <= 1'b1;
				in_buf[i] <= wr_data;
			end else if (sw_in_rd && sw_hit) begin
				in_byte_full_flag[i] <= 1'b0;
			end
		end
	end

	assign out_all_empty_flag = &out_byte_empty_flag;
	assign in_all_full_flag = &in_byte_full_flag;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sw_rdata <= ppu_pkg::BYTE_RESET;
		end else if (sw_in_rd) begin
			sw_rdata <= in_buf[sw_index];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			out_underflow_flag <= 1'b0;
		end else if (rd_ev && out_byte_empty_flag[sy.addr]) begin
			out_underflow_flag <= 1'b1;
		end else if (clr_underflow) begin
			out_underflow_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			in_overflow_flag <= 1'b0;
		end else if (wr_ev && in_byte_full_flag[wr_sel]) begin
			in_overflow_flag <= 1'b1;
		end else if (clr_overflow) begin
			in_overflow_flag <= 1'b0;
		end
	end

	// Master sequencer
	ppu_pkg::ppu_mst_state_type st;
	ppu_pkg::ppu_mst_state_type next_st;
	ppu_pkg::ppu_mst_state_type first_st;
	logic [2:0] cnt;
	logic op_write;
	logic [15:0] op_data;
	logic step_done;
	logic last;
	logic start_ok;

	// Reads hold the strobe until pin data has crossed the synchroniser
	assign step_done = op_write || cnt == 3'(MST_RD_CYCLES - 1);
	assign last = (st == ppu_pkg::M_DATA_HI && step_done)
		|| (st == ppu_pkg::M_DATA_LO && step_done && !wide_data_select);
	assign busy = st != ppu_pkg::M_IDLE && !last;
	assign start_ok = master_on && mst_start && !busy;

	always_comb begin
		if (addr_mux_select == ppu_pkg::MUX_PART || addr_mux_select == ppu_pkg::MUX_FULL) begin
			first_st = ppu_pkg::M_ADDR_LO;
		end else begin
			first_st = ppu_pkg::M_DATA_LO;
		end
	end

	always_comb begin
		next_st = st;
		case (st)
			ppu_pkg::M_IDLE: begin
				if (start_ok) begin
					next_st = first_st;
				end
			end
			ppu_pkg::M_ADDR_LO: begin
				if (addr_mux_select == ppu_pkg::MUX_FULL) begin
					next_st = ppu_pkg::M_ADDR_HI;
				end else begin
					next_st = ppu_pkg::M_DATA_LO;
				end
			end
			ppu_pkg::M_ADDR_HI: next_st = ppu_pkg::M_DATA_LO;
			ppu_pkg::M_DATA_LO: begin
				if (step_done && wide_data_select) begin
					next_st = ppu_pkg::M_DATA_HI;
				end else if (last) begin
					next_st = start_ok ? first_st : ppu_pkg::M_IDLE;
				end
			end
			ppu_pkg::M_DATA_HI: begin
				if (last) begin
					next_st = start_ok ? first_st : ppu_pkg::M_IDLE;
				end
			end
			default: next_st = ppu_pkg::M_IDLE;
		endcase
		if (!master_on) begin
			next_st = ppu_pkg::M_IDLE;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st <= ppu_pkg::M_IDLE;
		end else begin
			st <= next_st;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst || next_st != st || last) begin
			cnt <= 3'h0;
		end else if (st != ppu_pkg::M_IDLE) begin
			cnt <= cnt + 3'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			op_write <= 1'b0;
			op_data <= 16'h0000;
		end else if (start_ok) begin
			op_write <= mst_write;
			op_data <= mst_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			mst_rdata <= 16'h0000;
		end else if (!op_write && cnt == 3'(MST_RD_CYCLES - 1)) begin
			if (st == ppu_pkg::M_DATA_LO) begin
				mst_rdata[7:0] <= sy.data;
			end else if (st == ppu_pkg::M_DATA_HI) begin
				mst_rdata[15:8] <= sy.data;
			end
		end
	end

	// Address counter
	logic [15:0] cnt_mask;
	logic [15:0] stepped;
	logic step_on;
	assign step_on = addr_step_mode == ppu_pkg::STEP_INC || addr_step_mode == ppu_pkg::STEP_DEC;

	always_comb begin
		case (cs_func)
			ppu_pkg::CSF_BOTH: cnt_mask = ppu_pkg::MASK_NO_CS;
			ppu_pkg::CSF_ONE: cnt_mask = ppu_pkg::MASK_NO_CS2;
			default: cnt_mask = ppu_pkg::MASK_ALL;
		endcase
		if (addr_step_mode == ppu_pkg::STEP_INC) begin
			stepped = master_address_reg + ppu_pkg::ADDR_STEP;
		end else begin
			stepped = master_address_reg - ppu_pkg::ADDR_STEP;
		end
	end

	// A load from software takes priority over a step in the same cycle
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			master_address_reg <= ppu_pkg::ADDR_RESET;
		end else if (addr_load && !busy) begin
			master_address_reg <= addr_load_value;
		end else if (last && step_on) begin
			master_address_reg <= (stepped & cnt_mask) | (master_address_reg & ~cnt_mask);
		end
	end

	// Pin drive, registered one cycle behind the sequencer
	logic cs1_on;
	logic cs2_on;
	logic in_data;
	logic [7:0] hi_byte;
	logic [7:0] next_data;
	logic next_data_oe_n;
	logic next_rd;
	logic next_wr;
	logic next_be;
	logic [15:0] next_addr;
	logic [15:0] next_addr_oe_n;
	assign cs2_on = cs_func == ppu_pkg::CSF_BOTH || cs_func == ppu_pkg::CSF_ONE;
	assign cs1_on = cs_func == ppu_pkg::CSF_BOTH;
	assign in_data = st == ppu_pkg::M_DATA_LO || st == ppu_pkg::M_DATA_HI;

	always_comb begin
		hi_byte = master_address_reg[15:8];
		hi_byte[ppu_pkg::HI_CS2] = cs2_on ? 1'b0 : hi_byte[ppu_pkg::HI_CS2];
		hi_byte[ppu_pkg::HI_CS1] = cs1_on ? 1'b0 : hi_byte[ppu_pkg::HI_CS1];
		next_data = ppu_pkg::BYTE_RESET;
		next_data_oe_n = 1'b1;
		next_addr = master_address_reg;
		next_addr_oe_n = master_on ? ~addr_pin_enables : '1;
		next_addr[ppu_pkg::PIN_CS2] = cs2_on ?
			act(pol_cs2, master_address_reg[ppu_pkg::PIN_CS2] && st != ppu_pkg::M_IDLE) :
			master_address_reg[ppu_pkg::PIN_CS2];
		next_addr[ppu_pkg::PIN_CS1] = cs1_on ?
			act(pol_cs1, master_address_reg[ppu_pkg::PIN_CS1] && st != ppu_pkg::M_IDLE) :
			master_address_reg[ppu_pkg::PIN_CS1];
		if (addr_mux_select == ppu_pkg::MUX_PART || addr_mux_select == ppu_pkg::MUX_FULL) begin
			next_addr[ppu_pkg::PIN_LATCH_LO] = act(pol_latch, st == ppu_pkg::M_ADDR_LO);
		end
		if (addr_mux_select == ppu_pkg::MUX_FULL) begin
			next_addr[ppu_pkg::PIN_LATCH_HI] = act(pol_latch, st == ppu_pkg::M_ADDR_HI);
		end
		if (port_mode == ppu_pkg::MODE_MST_COMB) begin
			next_rd = act(pol_read, st != ppu_pkg::M_IDLE && !op_write);
			next_wr = act(pol_write, in_data);
		end else begin
			next_rd = act(pol_read, in_data && !op_write);
			next_wr = act(pol_write, in_data && op_write);
		end
		next_be = act(pol_be, st == ppu_pkg::M_DATA_HI);
		if (master_on) begin
			case (st)
				ppu_pkg::M_ADDR_LO: begin
					next_data = master_address_reg[7:0];
					next_data_oe_n = 1'b0;
				end
				ppu_pkg::M_ADDR_HI: begin
					next_data = hi_byte;
					next_data_oe_n = 1'b0;
				end
				ppu_pkg::M_DATA_LO: begin
					next_data = op_data[7:0];
					next_data_oe_n = !op_write;
				end
				ppu_pkg::M_DATA_HI: begin
					next_data = op_data[15:8];
					next_data_oe_n = !op_write;
				end
				default: next_data_oe_n = 1'b1;
			endcase
		end else if (slave_on && rd_act) begin
			next_data = out_buf[sy.addr];
			next_data_oe_n = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			port_data_out <= ppu_pkg::BYTE_RESET;
			port_data_oe_n <= 1'b1;
			addr_pin_out <= ppu_pkg::ADDR_RESET;
			addr_pin_oe_n <= '1;
			read_strobe_out <= 1'b0;
			read_strobe_oe_n <= 1'b1;
			write_strobe_out <= 1'b0;
			write_strobe_oe_n <= 1'b1;
			high_byte_strobe <= 1'b0;
			high_byte_oe_n <= 1'b1;
		end else begin
			port_data_out <= next_data;
			port_data_oe_n <= next_data_oe_n;
			addr_pin_out <= next_addr;
			addr_pin_oe_n <= next_addr_oe_n;
			read_strobe_out <= next_rd;
			read_strobe_oe_n <= !(master_on && read_pin_enable);
			write_strobe_out <= next_wr;
			write_strobe_oe_n <= !(master_on && write_pin_enable);
			high_byte_strobe <= next_be;
			high_byte_oe_n <= !(master_on && byte_en_pin_enable);
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	a_read_sets_empty: assert property (rd_ev |=> out_byte_empty_flag[$past(sy.addr)])
		else $error("host read did not set the byte empty flag");
	a_underflow_event: assert property (rd_ev && out_byte_empty_flag[sy.addr] |=> out_underflow_flag)
		else $error("read of empty byte raised no underflow");
	a_write_fills: assert property (wr_ev && !in_byte_full_flag[wr_sel]
		|=> in_byte_full_flag[$past(wr_sel)] && in_buf[$past(wr_sel)] == $past(wr_data))
		else $error("host write did not fill the input byte");
	a_overflow_drops: assert property (wr_ev && in_byte_full_flag[wr_sel]
		|=> in_overflow_flag && in_buf[$past(wr_sel)] == $past(in_buf[wr_sel]))
		else $error("overflowing write was not dropped");
	a_slave_drives: assert property (slave_on && rd_act && !master_on
		|=> !port_data_oe_n && port_data_out == $past(out_buf[sy.addr]))
		else $error("slave read drove the wrong byte");
	a_master_gate: assert property (!master_on |=> st == ppu_pkg::M_IDLE)
		else $error("sequencer ran outside master mode");
	a_full_mux_seq: assert property (start_ok && addr_mux_select == ppu_pkg::MUX_FULL && master_on
		|=> st == ppu_pkg::M_ADDR_LO ##1 st == ppu_pkg::M_ADDR_HI ##1 st == ppu_pkg::M_DATA_LO)
		else $error("full multiplex address phases out of order");
	a_hi_cs_zero: assert property (master_on && st == ppu_pkg::M_ADDR_HI && cs1_on
		|=> port_data_out[ppu_pkg::HI_CS2:ppu_pkg::HI_CS1] == 2'h0)
		else $error("chip select bits leaked into high address byte");
	a_single_no_busy: assert property (start_ok && st == ppu_pkg::M_IDLE && mst_write
		&& addr_mux_select == ppu_pkg::MUX_DEMUX && !wide_data_select |-> ##1 !busy)
		else $error("single-cycle write showed busy");
	a_step_keeps_cs: assert property (last && step_on && !addr_load && cs1_on
		|=> master_address_reg[15:14] == $past(master_address_reg[15:14]))
		else $error("chip select bits changed while stepping");
	a_be_high_byte: assert property (master_on && st == ppu_pkg::M_DATA_HI
		|=> high_byte_strobe == $past(pol_be))
		else $error("byte strobe not active in high byte");

	c_host_read: cover property (rd_ev);
	c_overflow: cover property (wr_ev && in_byte_full_flag[wr_sel]);
	c_wide_op: cover property (st == ppu_pkg::M_DATA_HI ##1 st == ppu_pkg::M_IDLE);
	c_full_mux: cover property (start_ok && addr_mux_select == ppu_pkg::MUX_FULL);
endmodule

// [logic/ppu_sync_if.sv]
// Synchronised slave-side pin levels
interface ppu_sync_if;
	logic cs;
	logic rd;
	logic wr;
	logic [1:0] addr;
	logic [7:0] data;
	modport src(output cs, rd, wr, addr, data);
	modport dst(input cs, rd, wr, addr, data);
endinterface

// [tb/ppu_far_mem.sv]
// Far-side memory model answering master reads
module ppu_far_mem (
	// Clock
	input wire logic clk_sys,
	// Pins seen from the device
	input wire logic rd_active,
	input wire logic byte_hi,
	input wire logic [7:0] addr_lo,
	// Data returned to the device
	output logic [7:0] rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] last = 8'h00;
	logic [7:0] word;
	assign word = addr_lo ^ (byte_hi ? 8'hc3 : 8'h5a);
	always_ff @(posedge clk_sys) begin
		if (rd_active) begin
			last <= word;
		end
	end
	// Released bus shows the inverse, so a late sample never matches by luck
	assign rd_data = rd_active ? word : ~last;
endmodule

// [tb/testbench.sv]
// Self-checking bench for the parallel port unit
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic port_unit_enable, wide_data_select, byte_en_pin_enable, write_pin_enable;
	logic read_pin_enable, pol_read, pol_write, pol_be, pol_latch, pol_cs1, pol_cs2;
	logic sw_out_wr, sw_in_rd, clr_underflow, clr_overflow, addr_load, mst_start;
	logic mst_write, slave_select, read_strobe_in, write_strobe_in, in_all_full_flag;
	logic out_all_empty_flag, out_underflow_flag, in_overflow_flag, busy, rd_act;
	logic read_strobe_out, read_strobe_oe_n, write_strobe_out, write_strobe_oe_n;
	logic port_data_oe_n, high_byte_strobe, high_byte_oe_n;
	logic [1:0] port_mode, addr_mux_select, addr_step_mode, cs_func, sw_index;
	logic [1:0] slave_addr_inputs;
	logic [3:0] out_byte_empty_flag, in_byte_full_flag;
	logic [7:0] sw_wdata, sw_rdata, port_data_in, port_data_out, host_data, mem_data, q;
	logic [15:0] addr_pin_enables, addr_load_value, mst_wdata, mst_rdata;
	logic [15:0] master_address_reg, addr_pin_out, addr_pin_oe_n;
	int errors = 0;
	int samples_checked = 0;
	always #10 clk_sys = ~clk_sys;
	assign rd_act = ~read_strobe_oe_n & read_strobe_out & ~write_strobe_oe_n & write_strobe_out;
	assign port_data_in = port_mode[1] ? mem_data : host_data;
	ppu_port #(.MST_RD_CYCLES(5)) dut (.clk_sys, .srst, .port_unit_enable, .port_mode,
		.wide_data_select, .addr_mux_select, .addr_step_mode, .cs_func, .byte_en_pin_enable,
		.write_pin_enable, .read_pin_enable, .addr_pin_enables, .pol_read, .pol_write, .pol_be,
		.pol_latch, .pol_cs1, .pol_cs2, .sw_out_wr, .sw_in_rd, .sw_index, .sw_wdata, .sw_rdata,
		.out_byte_empty_flag, .out_all_empty_flag, .in_byte_full_flag, .in_all_full_flag,
		.out_underflow_flag, .in_overflow_flag, .clr_underflow, .clr_overflow, .addr_load,
		.addr_load_value, .mst_start, .mst_write, .mst_wdata, .mst_rdata, .master_address_reg,
		.busy, .slave_select, .slave_addr_inputs, .read_strobe_in, .read_strobe_out,
		.read_strobe_oe_n, .write_strobe_in, .write_strobe_out, .write_strobe_oe_n,
		.port_data_in, .port_data_out, .port_data_oe_n, .high_byte_strobe, .high_byte_oe_n,
		.addr_pin_out, .addr_pin_oe_n);
	ppu_far_mem mem (.clk_sys, .rd_active(rd_act), .byte_hi(high_byte_strobe & ~high_byte_oe_n),
		.addr_lo(addr_pin_out[7:0]), .rd_data(mem_data));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic host_wr(input logic [1:0] a, input logic [7:0] d);
		slave_select = 1'b1;
		write_strobe_in = 1'b1;
		slave_addr_inputs = a;
		host_data = d;
		cyc(4);
		slave_select = 1'b0;
		write_strobe_in = 1'b0;
		cyc(1);
		host_data = ~d;
		cyc(5);
	endtask
	task automatic host_rd(input logic [1:0] a, input logic [7:0] d);
		slave_select = 1'b1;
		read_strobe_in = 1'b1;
		slave_addr_inputs = a;
		cyc(6);
		chk("slave read data", {8'h00, d}, {8'h00, port_data_out});
		chk("slave read drive", 16'h0000, {15'h0000, port_data_oe_n});
		slave_select = 1'b0;
		read_strobe_in = 1'b0;
		cyc(6);
	endtask
	task automatic sw_pulse(input logic wr, input logic [1:0] i, input logic [7:0] d);
		sw_out_wr = wr;
		sw_in_rd = ~wr;
		sw_index = i;
		sw_wdata = d;
		cyc(1);
		sw_out_wr = 1'b0;
		sw_in_rd = 1'b0;
		q = sw_rdata;
		cyc(1);
	endtask
	task automatic mst_go(input logic wr, input logic [15:0] a, input logic [15:0] d);
		addr_load = 1'b1;
		addr_load_value = a;
		cyc(1);
		addr_load = 1'b0;
		mst_start = 1'b1;
		mst_write = wr;
		mst_wdata = d;
		cyc(1);
		mst_start = 1'b0;
	endtask
	task automatic t_slave_wr();
		for (int i = 0; i < 4; i++) begin
			host_wr(i[1:0], 8'h10 + i[7:0]);
			chk("full flag", 16'h0001, {15'h0000, in_byte_full_flag[i]});
		end
		chk("all full", 16'h0001, {15'h0000, in_all_full_flag});
		host_wr(2'h2, 8'hee);
		chk("overflow", 16'h0001, {15'h0000, in_overflow_flag});
		for (int i = 0; i < 4; i++) begin
			sw_pulse(1'b0, i[1:0], 8'h00);
			chk("input byte", {8'h00, 8'h10 + i[7:0]}, {8'h00, q});
		end
		chk("full cleared", 16'h0000, {12'h000, in_byte_full_flag});
	endtask
	task automatic t_slave_rd();
		for (int i = 0; i < 4; i++) begin
			sw_pulse(1'b1, i[1:0], 8'ha0 + i[7:0]);
		end
		chk("empty cleared", 16'h0000, {12'h000, out_byte_empty_flag});
		for (int i = 3; i >= 0; i--) begin
			host_rd(i[1:0], 8'ha0 + i[7:0]);
		end
		chk("all empty", 16'h0001, {15'h0000, out_all_empty_flag});
		host_rd(2'h1, 8'ha1);
		chk("underflow", 16'h0001, {15'h0000, out_underflow_flag});
		{clr_underflow, clr_overflow} = 2'h3;
		cyc(1);
		{clr_underflow, clr_overflow} = 2'h0;
		chk("sticky cleared", 16'h0000, {14'h0000, out_underflow_flag, in_overflow_flag});
		mst_go(1'b1, 16'h0005, 16'h0000);
		chk("no master in slave mode", 16'h0000, {15'h0000, busy});
	endtask
	task automatic t_mst_wr();
		logic [7:0] lo, hi, wd;
		port_mode = ppu_pkg::MODE_MST_SEP;
		addr_mux_select = ppu_pkg::MUX_FULL;
		cs_func = ppu_pkg::CSF_BOTH;
		addr_step_mode = ppu_pkg::STEP_INC;
		pol_write = 1'b0;
		cyc(2);
		mst_go(1'b1, 16'hc123, 16'h005e);
		repeat (12) begin
			if (!addr_pin_oe_n[0] && addr_pin_out[0]) lo = port_data_out;
			if (!addr_pin_oe_n[1] && addr_pin_out[1]) hi = port_data_out;
			if (!write_strobe_oe_n && !write_strobe_out) wd = port_data_out;
			cyc(1);
		end
		chk("address low on data", 16'h0023, {8'h00, lo});
		chk("address high, selects zero", 16'h0001, {8'h00, hi});
		chk("write data", 16'h005e, {8'h00, wd});
		chk("address stepped", 16'hc124, master_address_reg);
	endtask
	task automatic t_mst_rd();
		port_mode = ppu_pkg::MODE_MST_COMB;
		addr_mux_select = ppu_pkg::MUX_DEMUX;
		cs_func = 2'h0;
		addr_step_mode = ppu_pkg::STEP_DEC;
		wide_data_select = 1'b1;
		pol_write = 1'b1;
		cyc(2);
		mst_go(1'b0, 16'h0040, 16'h0000);
		for (int n = 0; n < 60 && busy !== 1'b0; n++) cyc(1);
		cyc(2);
		chk("read word", {8'h40 ^ 8'hc3, 8'h40 ^ 8'h5a}, mst_rdata);
		chk("address down", 16'h003f, master_address_reg);
	endtask
	task automatic t_mst_part();
		port_mode = ppu_pkg::MODE_MST_SEP;
		addr_mux_select = ppu_pkg::MUX_PART;
		cs_func = ppu_pkg::CSF_ONE;
		addr_step_mode = ppu_pkg::STEP_INC;
		wide_data_select = 1'b0;
		cyc(2);
		mst_go(1'b1, 16'hffff, 16'h0033);
		cyc(1);
		chk("latch low", 16'h0001, {15'h0000, addr_pin_out[0]});
		chk("partial address low", 16'h00ff, {8'h00, port_data_out});
		chk("high address and select", 16'h00ff, {8'h00, addr_pin_out[15:8]});
		cyc(1);
		chk("partial write data", 16'h0033, {8'h00, port_data_out});
		chk("strobes", 16'h0001, {14'h0000, read_strobe_out, write_strobe_out});
		chk("select bit kept", 16'h8000, master_address_reg);
		addr_mux_select = ppu_pkg::MUX_DEMUX;
		mst_go(1'b1, 16'h1234, 16'h00a5);
		chk("single write busy", 16'h0000, {15'h0000, busy});
		cyc(1);
		chk("demux address", 16'h1234, addr_pin_out);
		chk("demux data", 16'h00a5, {8'h00, port_data_out});
	endtask
	task automatic tally_and_finish();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		{port_unit_enable, wide_data_select, byte_en_pin_enable, write_pin_enable} = 4'h0;
		{read_pin_enable, sw_out_wr, sw_in_rd, clr_underflow, clr_overflow} = 5'h00;
		{addr_load, mst_start, mst_write, slave_select, read_strobe_in} = 5'h00;
		{pol_read, pol_write, pol_be, pol_latch, pol_cs1, pol_cs2} = 6'h3f;
		write_strobe_in = 1'b0;
		port_mode = ppu_pkg::MODE_ADDR_SLAVE;
		{addr_mux_select, addr_step_mode, cs_func, sw_index, slave_addr_inputs} = 10'h000;
		{sw_wdata, host_data} = 16'h0000;
		{addr_pin_enables, addr_load_value, mst_wdata} = 48'h0;
		cyc(8);
		srst = 1'b0;
		cyc(2);
		chk("pins released", 16'hffff, addr_pin_oe_n);
		chk("empty at reset", 16'h000f, {12'h000, out_byte_empty_flag});
		port_unit_enable = 1'b1;
		{byte_en_pin_enable, write_pin_enable, read_pin_enable} = 3'h7;
		addr_pin_enables = 16'hffff;
		t_slave_wr();
		t_slave_rd();
		t_mst_wr();
		t_mst_rd();
		t_mst_part();
		tally_and_finish();
	end
	initial begin
		#200us;
		errors++;
		tally_and_finish();
	end
endmodule
